// file: include/afs_pkg.sv
// Package for the amplifier fault, warning and AC diagnostic register bank
package afs_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_LINE_OUT_REPORT = 8'h0e;
  localparam logic [7:0] ADDR_CH_STATE = 8'h0f;
  localparam logic [7:0] ADDR_CH_FAULT = 8'h10;
  localparam logic [7:0] ADDR_GLOBAL_FAULT_1 = 8'h11;
  localparam logic [7:0] ADDR_GLOBAL_FAULT_2 = 8'h12;
  localparam logic [7:0] ADDR_WARNING = 8'h13;
  localparam logic [7:0] ADDR_PIN_MASK = 8'h14;
  localparam logic [7:0] ADDR_AC_CTRL_1 = 8'h15;
  localparam logic [7:0] ADDR_AC_CTRL_2 = 8'h16;
  localparam logic [7:0] ADDR_AC_IMP_CH1 = 8'h17;
  localparam logic [7:0] ADDR_AC_IMP_CH2 = 8'h18;
  localparam logic [7:0] ADDR_AC_PHASE_HI = 8'h1b;
  localparam logic [7:0] ADDR_AC_PHASE_LO = 8'h1c;
  localparam logic [7:0] ADDR_AC_STI_HI = 8'h1d;
  localparam logic [7:0] ADDR_AC_STI_LO = 8'h1e;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CH_STATE = 8'h55;
  localparam logic [7:0] RST_WARNING = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [1:0] STATE_FLOATING = 2'h1;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_SHORTED_LOAD_CH2 = 0;
  localparam int BIT_LINE_OUT_CH1 = 3;
  localparam int BIT_LINE_OUT_CH2 = 2;
  localparam int BIT_STATE_CH1_LO = 6;
  localparam int BIT_STATE_CH2_LO = 4;
  localparam int BIT_OC_CH1 = 7;
  localparam int BIT_OC_CH2 = 6;
  localparam int BIT_DC_CH1 = 3;
  localparam int BIT_DC_CH2 = 2;
  localparam int BIT_INVALID_CLOCK = 4;
  localparam int BIT_POWER_STAGE_OVERVOLTAGE = 3;
  localparam int BIT_BATTERY_OVERVOLTAGE = 2;
  localparam int BIT_POWER_STAGE_UNDERVOLTAGE = 1;
  localparam int BIT_BATTERY_UNDERVOLTAGE = 0;
  localparam int BIT_THERMAL_SHUTDOWN_GLOBAL_GLOBAL = 4;
  localparam int BIT_THERMAL_SHUTDOWN_GLOBAL_CH1 = 3;
  localparam int BIT_THERMAL_SHUTDOWN_GLOBAL_CH2 = 2;
  localparam int BIT_POR = 5;
  localparam int BIT_OTW_GLOBAL = 4;
  localparam int BIT_THERMAL_ALERT_CH1 = 3;
  localparam int BIT_THERMAL_ALERT_CH2 = 2;
  localparam int BIT_HIDE_OC = 7;
  localparam int BIT_HIDE_THERMAL_SHUTDOWN_GLOBAL = 6;
  localparam int BIT_HIDE_UV = 5;
  localparam int BIT_HIDE_OV = 4;
  localparam int BIT_HIDE_DC = 3;
  localparam int BIT_HIDE_CLAMP = 2;
  localparam int BIT_HIDE_CLIP = 1;
  localparam int BIT_HIDE_OTW = 0;
  localparam int BIT_AC_GAIN = 7;
  localparam int BIT_AC_ON_CH1 = 3;
  localparam int BIT_AC_ON_CH2 = 2;
  localparam int BIT_AC_LOOP = 7;
  localparam int BIT_AC_DURATION = 4;
  localparam int BIT_AC_DRIVE_LO = 2;

  // ************************************************************
  // Types
  // ************************************************************
  // Live conditions reported by the amplifier core
  typedef struct packed {
    logic ch2_shorted_load_flag;
    logic ch1_line_out_detected;
    logic ch2_line_out_detected;
    logic [1:0] ch1_state_readback;
    logic [1:0] ch2_state_readback;
    logic ch1_overcurrent_flag;
    logic ch2_overcurrent_flag;
    logic ch1_offset_fault_flag;
    logic ch2_offset_fault_flag;
    logic invalidClock;
    logic power_stage_overvoltage;
    logic battery_overvoltage;
    logic power_stage_undervoltage;
    logic battery_undervoltage;
    logic thermal_shutdown_global;
    logic thermal_shutdown_ch1;
    logic thermal_shutdown_ch2;
    logic thermal_alert_global;
    logic thermal_alert_ch1;
    logic thermal_alert_ch2;
    logic currentClamp;
    logic clipping;
  } afs_cond_t;

  // Results of one AC diagnostic run
  typedef struct packed {
    logic [7:0] measured_load_ohms_ch1;
    logic [7:0] measured_load_ohms_ch2;
    logic [15:0] phaseResult;
    logic [15:0] transfer_index;
  } afs_ac_result_t;

  // AC diagnostic settings driven into the measurement engine
  typedef struct packed {
    logic ac_test_gain_select;
    logic ac_test_on_ch1;
    logic ac_test_on_ch2;
    logic ac_test_self_loop;
    logic ac_test_duration;
    logic [1:0] ac_test_drive_level;
  } afs_ac_cfg_t;

  // Serial slave states
  typedef enum logic [2:0] {
    SER_IDLE, SER_ADDR, SER_ACK_ADDR, SER_RX, SER_ACK_RX, SER_TX, SER_ACK_TX
  } afs_ser_state_t;

endpackage

// file: hw/afs_reg_bank.sv
// Fault, warning and AC diagnostic register bank with its serial slave port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Report bit 0: channel 2 shorted load
// - Line-output detect: channel 1 bit 3, channel 2 bit 2
// - State readback ch1 7:6, ch2 5:4, reset floating
// - Overcurrent flags: channel 1 bit 7, channel 2 bit 6
// - Offset fault flags: channel 1 bit 3, channel 2 bit 2
// - Invalid input clock flagged in bit 4
// - Supply over/undervoltage flags in bits 3 to 0
// - Thermal shutdown flags: global 4, ch1 3, ch2 2
// - Warning bit 5 records logic power-on reset
// - Thermal alerts: global 4, ch1 3, ch2 2
// - Mask bits 7 to 2 gate the error pin
// - Mask bits 1, 0 gate the alert pin
// - Control 1 bit 7 selects gain 1 or 4
// - Control 1 bits 3, 2 enable per-channel AC test
// - Control 2 bit 7 enables self loopback
// - Control 2 bit 4 picks 32 or 64 cycles
// - Per-channel 8-bit impedance code at 0.2496 ohm/step
// - 16-bit phase result at 0x1B and 0x1C
// - 16-bit transfer index at 0x1D and 0x1E
// - Clear request wipes latched fault flags
module afs_reg_bank
  import afs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h6a // Arbitrary default slave address
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic sclIn, // Serial clock pin, from host
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOut, // Serial data drive value, always low
  output logic sdaOe, // High while pulling serial data low
  input wire afs_cond_t cond, // Live conditions from the amplifier core
  input wire logic faultClearReq, // One-cycle request to wipe latched faults
  input wire afs_ac_result_t acResult, // Finished AC measurement
  input wire logic acResultValid, // One-cycle strobe: acResult is new
  output afs_ac_cfg_t acCfg, // Settings for the AC measurement engine
  output logic errorOut, // Error pin, high while an unmasked fault other than invalid clock stands
  output logic alertOut // Alert pin, high while an unmasked warning stands
);

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic sclMeta_q; // First stage, read only by the second
  logic sclSync_q; // Safe serial clock level
  logic sclPrev_q; // Previous safe level, for edges
  logic sdaMeta_q; // First stage, read only by the second
  logic sdaSync_q; // Safe serial data level
  logic sdaPrev_q; // Previous safe level, for start/stop

  // Two flops per pin guard against metastability from the host clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclMeta_q <= sclIn;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  logic sclRise; // Serial clock rising edge
  logic sclFall; // Serial clock falling edge
  logic startCond; // Data falls while clock high
  logic stopCond; // Data rises while clock high
  assign sclRise = sclSync_q & ~sclPrev_q;
  assign sclFall = ~sclSync_q & sclPrev_q;
  assign startCond = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
  assign stopCond = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [7:0] lineOut_q; // Shorted-load and line-output report
  logic [7:0] chState_q; // Channel state readback
  logic [7:0] chFault_q; // Latched channel faults
  logic [7:0] glob1_q; // Latched clock and supply faults
  logic [7:0] glob2_q; // Latched thermal shutdowns
  logic [7:0] warn_q; // Warnings and power-on record
  logic [7:0] pinMask_q; // Pin gating masks
  logic [7:0] acCtl1_q; // AC diagnostic control 1
  logic [7:0] acCtl2_q; // AC diagnostic control 2
  afs_ac_result_t acRes_q; // Held AC results

  // Write request from the serial slave
  logic wrEn; // One-cycle write strobe
  logic [7:0] wrAddr; // Register pointer for the write
  logic [7:0] wrData; // Byte to write

  // ************************************************************
  // Status mirrors
  // ************************************************************
  // Diagnostic reports follow the core every cycle; reads never disturb them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lineOut_q <= RST_ZERO;
      chState_q <= RST_CH_STATE;
    end else begin
      lineOut_q <= RST_ZERO;
      lineOut_q[BIT_SHORTED_LOAD_CH2] <= cond.ch2_shorted_load_flag;
      lineOut_q[BIT_LINE_OUT_CH1] <= cond.ch1_line_out_detected;
      lineOut_q[BIT_LINE_OUT_CH2] <= cond.ch2_line_out_detected;
      chState_q <= {cond.ch1_state_readback, cond.ch2_state_readback,
                    STATE_FLOATING, STATE_FLOATING};
    end
  end

  // ************************************************************
  // Latched fault flags
  // ************************************************************
  logic [7:0] chFaultSet; // New channel fault events
  logic [7:0] glob1Set; // New clock and supply events
  logic [7:0] glob2Set; // New thermal shutdown events

  always_comb begin
    chFaultSet = RST_ZERO;
    chFaultSet[BIT_OC_CH1] = cond.ch1_overcurrent_flag;
    chFaultSet[BIT_OC_CH2] = cond.ch2_overcurrent_flag;
    chFaultSet[BIT_DC_CH1] = cond.ch1_offset_fault_flag;
    chFaultSet[BIT_DC_CH2] = cond.ch2_offset_fault_flag;
    glob1Set = RST_ZERO;
    glob1Set[BIT_INVALID_CLOCK] = cond.invalidClock;
    glob1Set[BIT_POWER_STAGE_OVERVOLTAGE] = cond.power_stage_overvoltage;
    glob1Set[BIT_BATTERY_OVERVOLTAGE] = cond.battery_overvoltage;
    glob1Set[BIT_POWER_STAGE_UNDERVOLTAGE] = cond.power_stage_undervoltage;
    glob1Set[BIT_BATTERY_UNDERVOLTAGE] = cond.battery_undervoltage;
    glob2Set = RST_ZERO;
    glob2Set[BIT_THERMAL_SHUTDOWN_GLOBAL_GLOBAL] = cond.thermal_shutdown_global;
    glob2Set[BIT_THERMAL_SHUTDOWN_GLOBAL_CH1] = cond.thermal_shutdown_ch1;
    glob2Set[BIT_THERMAL_SHUTDOWN_GLOBAL_CH2] = cond.thermal_shutdown_ch2;
  end

  // Flags stick until cleared; an event in the clear cycle still lands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chFault_q <= RST_ZERO;
      glob1_q <= RST_ZERO;
      glob2_q <= RST_ZERO;
    end else if (faultClearReq) begin
      chFault_q <= chFaultSet;
      glob1_q <= glob1Set;
      glob2_q <= glob2Set;
    end else begin
      chFault_q <= chFault_q | chFaultSet;
      glob1_q <= glob1_q | glob1Set;
      glob2_q <= glob2_q | glob2Set;
    end
  end

  // ************************************************************
  // Warnings
  // ************************************************************
  // Thermal alerts are live; the power-on record comes up set after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warn_q <= RST_WARNING;
    end else begin
      warn_q <= RST_ZERO;
      warn_q[BIT_POR] <= warn_q[BIT_POR] & ~faultClearReq;
      warn_q[BIT_OTW_GLOBAL] <= cond.thermal_alert_global;
      warn_q[BIT_THERMAL_ALERT_CH1] <= cond.thermal_alert_ch1;
      warn_q[BIT_THERMAL_ALERT_CH2] <= cond.thermal_alert_ch2;
    end
  end

  // ************************************************************
  // Host-writable controls
  // ************************************************************
  // Only the three control offsets accept data; status writes are dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinMask_q <= RST_ZERO;
      acCtl1_q <= RST_ZERO;
      acCtl2_q <= RST_ZERO;
    end else if (wrEn) begin
      case (wrAddr)
        ADDR_PIN_MASK: begin
          pinMask_q <= wrData;
        end
        ADDR_AC_CTRL_1: begin
          acCtl1_q <= wrData;
        end
        ADDR_AC_CTRL_2: begin
          acCtl2_q <= wrData;
        end
        default: begin
          pinMask_q <= pinMask_q;
        end
      endcase
    end
  end

  // Settings go out registered so the engine sees clean levels
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acCfg <= '0;
    end else begin
      acCfg.ac_test_gain_select <= acCtl1_q[BIT_AC_GAIN];
      acCfg.ac_test_on_ch1 <= acCtl1_q[BIT_AC_ON_CH1];
      acCfg.ac_test_on_ch2 <= acCtl1_q[BIT_AC_ON_CH2];
      acCfg.ac_test_self_loop <= acCtl2_q[BIT_AC_LOOP];
      acCfg.ac_test_duration <= acCtl2_q[BIT_AC_DURATION];
      acCfg.ac_test_drive_level <= acCtl2_q[BIT_AC_DRIVE_LO +: 2];
    end
  end

  // ************************************************************
  // AC results
  // ************************************************************
  // Results held until the next run finishes; the host is expected to wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acRes_q <= '0;
    end else if (acResultValid) begin
      acRes_q <= acResult;
    end
  end

  // ************************************************************
  // Output pins
  // ************************************************************
  logic errorNow; // Any unmasked fault except invalid clock, at this moment
  logic alertNow; // Any unmasked warning at this moment

  always_comb begin
    errorNow = (~pinMask_q[BIT_HIDE_OC] & (chFault_q[BIT_OC_CH1] | chFault_q[BIT_OC_CH2]))
      | (~pinMask_q[BIT_HIDE_THERMAL_SHUTDOWN_GLOBAL] & (|glob2_q))
      | (~pinMask_q[BIT_HIDE_UV] & (glob1_q[BIT_POWER_STAGE_UNDERVOLTAGE] | glob1_q[BIT_BATTERY_UNDERVOLTAGE]))
      | (~pinMask_q[BIT_HIDE_OV] & (glob1_q[BIT_POWER_STAGE_OVERVOLTAGE] | glob1_q[BIT_BATTERY_OVERVOLTAGE]))
      | (~pinMask_q[BIT_HIDE_DC] & (chFault_q[BIT_DC_CH1] | chFault_q[BIT_DC_CH2]))
      | (~pinMask_q[BIT_HIDE_CLAMP] & cond.currentClamp);
    alertNow = (~pinMask_q[BIT_HIDE_CLIP] & cond.clipping)
      | (~pinMask_q[BIT_HIDE_OTW] & (warn_q[BIT_OTW_GLOBAL] | warn_q[BIT_THERMAL_ALERT_CH1]
      | warn_q[BIT_THERMAL_ALERT_CH2]));
  end

  // Pins follow the flags one cycle later, from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      errorOut <= 1'b0;
      alertOut <= 1'b0;
    end else begin
      errorOut <= errorNow;
      alertOut <= alertNow;
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  function automatic logic [7:0] readReg(input logic [7:0] addr);
    logic [7:0] val;
    val = RST_ZERO;
    case (addr)
      ADDR_LINE_OUT_REPORT: val = lineOut_q;
      ADDR_CH_STATE: val = chState_q;
      ADDR_CH_FAULT: val = chFault_q;
      ADDR_GLOBAL_FAULT_1: val = glob1_q;
      ADDR_GLOBAL_FAULT_2: val = glob2_q;
      ADDR_WARNING: val = warn_q;
      ADDR_PIN_MASK: val = pinMask_q;
      ADDR_AC_CTRL_1: val = acCtl1_q;
      ADDR_AC_CTRL_2: val = acCtl2_q;
      ADDR_AC_IMP_CH1: val = acRes_q.measured_load_ohms_ch1;
      ADDR_AC_IMP_CH2: val = acRes_q.measured_load_ohms_ch2;
      ADDR_AC_PHASE_HI: val = acRes_q.phaseResult[15:8];
      ADDR_AC_PHASE_LO: val = acRes_q.phaseResult[7:0];
      ADDR_AC_STI_HI: val = acRes_q.transfer_index[15:8];
      ADDR_AC_STI_LO: val = acRes_q.transfer_index[7:0];
      default: val = RST_ZERO; // Unmapped offsets read as zero
    endcase
    return val;
  endfunction

  // ************************************************************
  // Serial slave
  // ************************************************************
  afs_ser_state_t state_q; // Slave state
  logic [3:0] bitCnt_q; // Bits seen in the current byte
  logic [7:0] shift_q; // Receive or transmit shift register
  logic [7:0] ptr_q; // Register pointer, auto-increments
  logic ptrPending_q; // Next received byte is the pointer
  logic readMode_q; // Current transfer is a read
  logic masterAck_q; // Host acked the last byte sent
  logic wrEn_q; // Write strobe flop
  logic [7:0] wrAddr_q; // Write address flop
  logic [7:0] wrData_q; // Write data flop

  logic [7:0] rdByte; // Register byte at the pointer, for loading the transmitter
  always_comb rdByte = readReg(ptr_q);

  assign wrEn = wrEn_q;
  assign wrAddr = wrAddr_q;
  assign wrData = wrData_q;

  // Bytes are sampled on rising clock and changed on falling clock.
  // A start or stop aborts whatever byte is in flight.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SER_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      ptrPending_q <= 1'b0;
      readMode_q <= 1'b0;
      masterAck_q <= 1'b0;
      sdaOe <= 1'b0;
      wrEn_q <= 1'b0;
      wrAddr_q <= 8'h00;
      wrData_q <= 8'h00;
    end else begin
      wrEn_q <= 1'b0;
      if (startCond) begin
        state_q <= SER_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state_q <= SER_IDLE;
        sdaOe <= 1'b0;
      end else if (sclRise) begin
        // Sample phase
        case (state_q)
          SER_ADDR, SER_RX: begin
            shift_q <= {shift_q[6:0], sdaSync_q};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          SER_TX: begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          SER_ACK_TX: begin
            masterAck_q <= ~sdaSync_q;
          end
          default: begin
            bitCnt_q <= bitCnt_q;
          end
        endcase
      end else if (sclFall) begin
        // Drive phase
        case (state_q)
          SER_ADDR: begin
            if (bitCnt_q == 4'h8) begin
              if (shift_q[7:1] == DEV_ADDR) begin
                state_q <= SER_ACK_ADDR;
                readMode_q <= shift_q[0];
                ptrPending_q <= ~shift_q[0];
                sdaOe <= 1'b1;
              end else begin
                state_q <= SER_IDLE;
              end
            end
          end
          SER_ACK_ADDR, SER_ACK_TX: begin
            bitCnt_q <= 4'h0;
            if (readMode_q && (state_q == SER_ACK_ADDR || masterAck_q)) begin
              // Load the next byte; reads leave every flag untouched
              state_q <= SER_TX;
              shift_q <= {rdByte[6:0], 1'b0};
              sdaOe <= ~rdByte[7];
              ptr_q <= ptr_q + 8'h01;
            end else if (readMode_q) begin
              state_q <= SER_IDLE;
              sdaOe <= 1'b0;
            end else begin
              state_q <= SER_RX;
              sdaOe <= 1'b0;
            end
          end
          SER_RX: begin
            if (bitCnt_q == 4'h8) begin
              state_q <= SER_ACK_RX;
              sdaOe <= 1'b1;
              if (ptrPending_q) begin
                ptr_q <= shift_q;
                ptrPending_q <= 1'b0;
              end else begin
                wrEn_q <= 1'b1;
                wrAddr_q <= ptr_q;
                wrData_q <= shift_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          SER_ACK_RX: begin
            state_q <= SER_RX;
            bitCnt_q <= 4'h0;
            sdaOe <= 1'b0;
          end
          SER_TX: begin
            if (bitCnt_q == 4'h8) begin
              state_q <= SER_ACK_TX;
              sdaOe <= 1'b0;
            end else begin
              sdaOe <= ~shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain: the pin is only ever pulled low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: bench/afs_host_model.sv
// Serial host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module afs_host_model #(
  parameter logic [6:0] DEV = 7'h6a // Arbitrary slave address
) (
  input wire logic clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic pull = 1'b0; // Host pulls data low
  initial sclIn = 1'b1;
  // Open-drain line, pulled up when nobody pulls
  assign sdaIn = !(pull || sdaOe);
  // Eight-clock phases, well above what the port needs
  task automatic tick(input logic c, input logic p);
    repeat (8) @(posedge clk);
    sclIn <= c;
    pull <= p;
  endtask
  // Data moves only while the clock is low; ninth bit is the ack slot
  task automatic byte9(input logic [8:0] d, output logic [7:0] q, output logic k);
    for (int i = 8; i >= 0; i--) begin
      tick(1'b0, pull);
      tick(1'b0, !d[i]);
      tick(1'b1, !d[i]);
      repeat (8) @(posedge clk);
      if (i > 0) q[i-1] = sdaIn;
      k = !sdaIn;
    end
  endtask
  // Four clock/data steps: start is 3/1, stop is 3/6
  task automatic seq(input logic [3:0] c, input logic [3:0] p);
    for (int i = 3; i >= 0; i--) tick(c[i], p[i]);
  endtask
  // Pointer write, then a data byte or a repeated start and one read byte
  task automatic xfer(input logic rdOp, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    logic k1, k2, k3;
    seq(4'h3, 4'h1);
    byte9({DEV, 1'b0, 1'b1}, q, k1);
    byte9({a, 1'b1}, q, k2);
    if (rdOp) seq(4'h3, 4'h1);
    byte9(rdOp ? {DEV, 1'b1, 1'b1} : {d, 1'b1}, q, k3);
    ok = k1 & k2 & k3;
    if (rdOp) byte9(9'h1ff, q, k3);
    seq(4'h3, 4'h6);
  endtask
endmodule
`default_nettype wire

// file: bench/afs_reg_bank_sva.sv
// Checker on the ports of the register bank
`timescale 1ns/1ps
`default_nettype none
module afs_reg_bank_sva
  import afs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire afs_cond_t cond,
  input wire logic faultClearReq,
  input wire afs_ac_cfg_t acCfg,
  input wire logic errorOut,
  input wire logic alertOut
);
  logic faultAny, warnAny;
  // faultAny is wider than the error pin set on purpose; warnAny matches the alert pin set
  assign faultAny = |cond[16:1];
  assign warnAny = |cond[4:2] | cond[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_sda_only_low: assert property (sdaOut == 1'b0) else $error("data driven high");
  chk_ack_scl_low: assert property ($changed(sdaOe) |-> !sclIn) else $error("data moved in clock high");
  chk_cfg_by_write: assert property ($changed(acCfg) |-> $past(sdaOe)) else $error("cfg moved");
  chk_cfg_after_reset: assert property ($rose(nrst) |-> acCfg == '0) else $error("cfg reset");
  chk_pins_after_reset: assert property ($rose(nrst) |-> !errorOut && !alertOut) else $error("pin reset");
  // Clipping reaches the pin one cycle sooner than the registered warnings
  chk_alert_quiet: assert property (!$past(warnAny, 2) && !$past(warnAny) |-> !alertOut)
    else $error("alert uncaused");
  // Current clamp is live and reaches the pin one cycle sooner than latched faults
  chk_error_cause: assert property ($rose(errorOut) |-> $past(faultAny, 2) || $past(faultAny) || $past(sdaOe))
    else $error("error uncaused");
  chk_error_clear: assert property (faultClearReq && !faultAny |-> ##2 !errorOut)
    else $error("error kept");
endmodule
`default_nettype wire

// file: bench/afs_reg_bank_bench.sv
// Self-checking bench for the fault and AC diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errTotal++; $display("BAD %s exp %h got %h", nm, e, g); end end
module afs_reg_bank_bench
  import afs_pkg::*;
();
  logic clk = 1'b0, nrst = 1'b0, faultClearReq = 1'b0, acResultValid = 1'b0;
  afs_cond_t cond = '0;
  afs_ac_result_t acResult = '0;
  afs_ac_cfg_t acCfg;
  logic sclIn, sdaIn, sdaOut, sdaOe, errorOut, alertOut, ok;
  logic [7:0] q;
  int errTotal = 0, compares = 0;
  // One-hot condition bit 2..23 to {offset, byte}
  logic [15:0] tbl [2:23] = '{16'h1304, 16'h1308, 16'h1310, 16'h1204, 16'h1208, 16'h1210, 16'h1101,
    16'h1102, 16'h1104, 16'h1108, 16'h1110, 16'h1004, 16'h1008, 16'h1040, 16'h1080, 16'h0f15, 16'h0f25,
    16'h0f45, 16'h0f85, 16'h0e04, 16'h0e08, 16'h0e01};
  // Result bytes of 48'hff01a55ac33c by offset
  logic [15:0] res [0:5] = '{16'h17ff, 16'h1801, 16'h1ba5, 16'h1c5a, 16'h1dc3, 16'h1e3c};
  afs_reg_bank afs_reg_bank_i (.clk, .nrst, .sclIn, .sdaIn, .sdaOut, .sdaOe, .cond, .faultClearReq, .acResult,
    .acResultValid, .acCfg, .errorOut, .alertOut);
  afs_host_model afs_host_model_i (.clk, .sdaOe, .sclIn, .sdaIn);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    afs_host_model_i.xfer(1'b0, a, d, q, ok);
    `CHK("ack", 1'b1, ok)
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    afs_host_model_i.xfer(1'b1, a, 8'h00, q, ok);
    `CHK("ack", 1'b1, ok)
    `CHK("reg", e, q)
  endtask
  // One-cycle clear pulse
  task automatic clr;
    @(posedge clk) faultClearReq <= 1'b1;
    @(posedge clk) faultClearReq <= 1'b0;
  endtask
  // Pins settle two clocks after their cause
  task automatic pins(input logic e, input logic a);
    repeat (3) @(posedge clk);
    `CHK("errorOut", e, errorOut)
    `CHK("alertOut", a, alertOut)
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ADDR_WARNING, 8'h00);
    wr(ADDR_CH_STATE, 8'h00);
    // State readback follows the core, which reports both channels playing here
    for (int a = 14; a <= 30; a++) rd(8'(a), a == 15 ? 8'h05 : a == 19 ? 8'h20 : 8'h00);
    $display("test reset values done");
    for (int i = 2; i <= 23; i++) begin
      clr();
      cond <= afs_cond_t'(24'h1 << i);
      rd(tbl[i][15:8], tbl[i][7:0]);
      cond <= '0;
    end
    $display("test status flags done");
    wr(ADDR_PIN_MASK, 8'hff);
    cond <= afs_cond_t'(24'h10012); // Overcurrent, thermal alert, clamp
    pins(1'b0, 1'b0);
    wr(ADDR_PIN_MASK, 8'hfb);
    pins(1'b1, 1'b0);
    wr(ADDR_PIN_MASK, 8'h7e);
    pins(1'b1, 1'b1);
    cond <= '0;
    pins(1'b1, 1'b0);
    wr(ADDR_PIN_MASK, 8'h7d);
    cond <= afs_cond_t'(24'h1); // Clipping alone
    pins(1'b1, 1'b1);
    cond <= '0;
    pins(1'b1, 1'b0);
    rd(ADDR_CH_FAULT, 8'h80);
    clr();
    pins(1'b0, 1'b0);
    $display("test pins done");
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_AC_CTRL_1, k ? 8'h08 : 8'h8c);
      wr(ADDR_AC_CTRL_2, k ? 8'h00 : 8'h94);
      `CHK("acCfg", k ? 7'h20 : 7'h7d, acCfg)
      rd(ADDR_AC_CTRL_2, k ? 8'h00 : 8'h94);
    end
    acResult <= 48'hff01a55ac33c;
    acResultValid <= 1'b1;
    @(posedge clk) acResultValid <= 1'b0;
    // Results are read only after the capture strobe has passed
    for (int j = 0; j < 6; j++) rd(res[j][15:8], res[j][7:0]);
    $display("test ac diagnostic done");
    print_verdict();
  end
  // Hang guard, about half again the expected run
  initial begin
    #(8 * 100000);
    errTotal++;
    $display("BAD watchdog exp done got hang");
    print_verdict();
  end
endmodule
bind afs_reg_bank afs_reg_bank_sva afs_reg_bank_sva_i (.clk, .nrst, .sclIn, .sdaOut, .sdaOe, .cond,
  .faultClearReq, .acCfg, .errorOut, .alertOut);
`default_nettype wire
